// ==== logic/gx_pkg.sv ====
// constants, bus carriers and helpers for the gesture entry/exit controller
package gx_pkg;

  // clock and wait timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WAIT_UNIT_NS = 2800000; // one wait step
  localparam int unsigned WAIT_UNIT_CYC = WAIT_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned WAIT_CNT_W = 20; // holds seven steps

  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_THR = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;

  // wait/gain/drive config byte layout
  localparam int unsigned CFG_ENAL_BIT = 7;
  localparam int unsigned CFG_GAIN_LSB = 5;
  localparam int unsigned CFG_DRIVE_LSB = 3;
  localparam int unsigned CFG_WAIT_LSB = 0;
  localparam logic [7:0] CFG_RST = 8'h00;

  // control register bits
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;

  // threshold register layout
  localparam int unsigned THR_ENTRY_LSB = 0;
  localparam int unsigned THR_EXIT_LSB = 8;
  localparam int unsigned THR_MASK_LSB = 16;
  localparam int unsigned THR_PERS_LSB = 20;
  localparam int unsigned THR_W = 22;
  localparam logic [THR_W-1:0] THR_RST = 22'h000000;

  // status register layout
  localparam int unsigned STAT_ST_LSB = 0;
  localparam int unsigned STAT_CNT_LSB = 2;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // master to slave side of the register bus
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } gx_axil_req_t;

  // slave to master side of the register bus
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gx_axil_rsp_t;

  // one directional dataset; mask bits 3..0 are n, s, w, e
  typedef struct packed {
    logic [7:0] n;
    logic [7:0] s;
    logic [7:0] w;
    logic [7:0] e;
  } gx_dirs_t;

  // controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GEST = 2'b01,
    ST_WAIT = 2'b10
  } gx_state_t;

  // persistence code to number of consecutive ends
  function automatic logic [2:0] pers_count(input logic [1:0] code);
    case (code)
      2'h0: pers_count = 3'h1;
      2'h1: pers_count = 3'h2;
      2'h2: pers_count = 3'h4;
      default: pers_count = 3'h7;
    endcase
  endfunction : pers_count

  // byte-lane merge for strobed writes
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : wmerge

endpackage : gx_pkg

// ==== logic/gx_exit_filter.sv ====
// gesture-end detection and exit persistence counter
`timescale 1ns/100ps
module gx_exit_filter (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cycle_done,
  input wire gx_pkg::gx_dirs_t dirs,
  input wire logic [7:0] exit_threshold,
  input wire logic [3:0] exit_detector_mask,
  input wire logic [1:0] exit_persistence,
  input wire logic clear_cnt,
  output logic end_det,
  output logic exit_req,
  output logic [2:0] end_count
);

  // all state of this module
  typedef struct packed {
    logic [2:0] cnt; // consecutive ends, saturating
  } gx_flt_t;

  gx_flt_t s_r;
  gx_flt_t s_nxt;
  logic [3:0] below; // per detector: under threshold or masked
  logic [3:0] cnt_inc;

  // end when every unmasked detector sits under the exit threshold
  always_comb begin
    below[3] = exit_detector_mask[3] || (dirs.n < exit_threshold);
    below[2] = exit_detector_mask[2] || (dirs.s < exit_threshold);
    below[1] = exit_detector_mask[1] || (dirs.w < exit_threshold);
    below[0] = exit_detector_mask[0] || (dirs.e < exit_threshold);
    // a zero threshold can never be undercut, so nothing ends
    end_det = (&below) && (exit_threshold != 8'h00);
  end

  assign cnt_inc = {1'b0, s_r.cnt} + 4'h1;
  // exit once this end brings the run to the persistence count
  assign exit_req = cycle_done && end_det &&
                    (cnt_inc >= {1'b0, gx_pkg::pers_count(exit_persistence)});
  assign end_count = s_r.cnt;

  // counter update; entry clear has priority over counting
  always_comb begin
    s_nxt = s_r;
    if (clear_cnt) begin
      s_nxt.cnt = 3'h0;
    end else if (cycle_done) begin
      if (!end_det) begin
        s_nxt.cnt = 3'h0;
      end else if (s_r.cnt != 3'h7) begin
        s_nxt.cnt = cnt_inc[2:0];
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_zero_thr_hold: assert property (exit_threshold == 8'h00 |-> !exit_req)
    else $error("exit raised with zero exit threshold");
  a_miss_clears: assert property (
      cycle_done && !end_det && !clear_cnt |=> end_count == 3'h0)
    else $error("end counter kept after a missed end");
  a_exit_at_cnt: assert property (
      cycle_done && end_det &&
      {1'b0, end_count} + 4'h1 == {1'b0, gx_pkg::pers_count(exit_persistence)} |-> exit_req)
    else $error("no exit at persistence count");
  a_east_blocks: assert property (
      !exit_detector_mask[0] && dirs.e >= exit_threshold |-> !end_det)
    else $error("unmasked detector over threshold gave an end");

endmodule : gx_exit_filter

// ==== logic/gx_gesture_ctrl.sv ====
// gesture entry/exit controller with its register slave
`timescale 1ns/100ps
module gx_gesture_ctrl #(
  parameter int unsigned WAIT_CYC = gx_pkg::WAIT_UNIT_CYC // cycles per wait step
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire gx_pkg::gx_axil_req_t axi_req,
  output gx_pkg::gx_axil_rsp_t axi_rsp,
  input wire logic prox_valid,
  input wire logic [7:0] proximity_result,
  input wire logic cycle_done,
  input wire gx_pkg::gx_dirs_t dirs,
  output logic gesture_active,
  output logic cycle_req,
  output logic low_power,
  output logic [3:0] gain_mult,
  output logic [1:0] led_drive_shift
);

  // all state of the controller and its bus slave
  typedef struct packed {
    gx_pkg::gx_state_t st; // engine state
    logic [gx_pkg::WAIT_CNT_W-1:0] wait_cnt; // low-power cycles left
    logic [7:0] cfg; // wait/gain/drive byte
    logic en; // gesture enable bit
    logic mode; // gesture state bit
    logic [gx_pkg::THR_W-1:0] thr; // thresholds, mask, persistence
    logic aw_held; // write address latched
    logic [7:0] aw_addr;
    logic w_held; // write data latched
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] gain; // registered gain output
    logic [1:0] drive; // registered drive output
  } gx_ctrl_t;

  gx_ctrl_t s_r;
  gx_ctrl_t s_nxt;

  // field views
  logic enter_always;
  logic [1:0] photodiode_gain_sel;
  logic [1:0] led_drive_strength;
  logic [2:0] inter_cycle_wait;
  logic [7:0] entry_threshold;
  logic [7:0] exit_threshold;
  logic [3:0] exit_detector_mask;
  logic [1:0] exit_persistence;

  // handshakes and internal strobes
  logic aw_go; // address taken this edge
  logic w_go; // data taken this edge
  logic ar_go; // read address taken this edge
  logic sw_wr; // latched write applied this edge
  logic entry_ok; // proximity result qualifies for entry
  logic clear_cnt; // entering, reset end counter
  logic end_det;
  logic exit_req;
  logic [2:0] end_count;
  logic [31:0] wr_old; // current value of the written register

  assign enter_always = s_r.cfg[gx_pkg::CFG_ENAL_BIT];
  assign photodiode_gain_sel = s_r.cfg[gx_pkg::CFG_GAIN_LSB +: 2];
  assign led_drive_strength = s_r.cfg[gx_pkg::CFG_DRIVE_LSB +: 2];
  assign inter_cycle_wait = s_r.cfg[gx_pkg::CFG_WAIT_LSB +: 3];
  assign entry_threshold = s_r.thr[gx_pkg::THR_ENTRY_LSB +: 8];
  assign exit_threshold = s_r.thr[gx_pkg::THR_EXIT_LSB +: 8];
  assign exit_detector_mask = s_r.thr[gx_pkg::THR_MASK_LSB +: 4];
  assign exit_persistence = s_r.thr[gx_pkg::THR_PERS_LSB +: 2];

  // bus ready terms; a channel is refused while its item is parked
  assign axi_rsp.awready = !s_r.aw_held && !s_r.bvalid;
  assign axi_rsp.wready = !s_r.w_held && !s_r.bvalid;
  assign axi_rsp.arready = !s_r.rvalid;
  assign axi_rsp.bvalid = s_r.bvalid;
  assign axi_rsp.bresp = s_r.bresp;
  assign axi_rsp.rvalid = s_r.rvalid;
  assign axi_rsp.rdata = s_r.rdata;
  assign axi_rsp.rresp = s_r.rresp;
  assign aw_go = axi_req.awvalid && axi_rsp.awready;
  assign w_go = axi_req.wvalid && axi_rsp.wready;
  assign ar_go = axi_req.arvalid && axi_rsp.arready;
  // write commits one edge after both halves are parked
  assign sw_wr = s_r.aw_held && s_r.w_held && !s_r.bvalid;

  // entry qualification by proximity result
  assign entry_ok = enter_always || (proximity_result >= entry_threshold);

  // engine-facing outputs
  assign gesture_active = (s_r.st != gx_pkg::ST_IDLE);
  assign cycle_req = (s_r.st == gx_pkg::ST_GEST);
  assign low_power = (s_r.st == gx_pkg::ST_WAIT);
  assign gain_mult = s_r.gain;
  assign led_drive_shift = s_r.drive;

  // end detection and persistence live in the filter
  gx_exit_filter gx_exit_filter_i (
    .core_clk(core_clk),
    .srst(srst),
    .cycle_done(cycle_done && (s_r.st == gx_pkg::ST_GEST)),
    .dirs(dirs),
    .exit_threshold(exit_threshold),
    .exit_detector_mask(exit_detector_mask),
    .exit_persistence(exit_persistence),
    .clear_cnt(clear_cnt),
    .end_det(end_det),
    .exit_req(exit_req),
    .end_count(end_count)
  );

  // current value of the addressed register, for strobe merging
  always_comb begin
    case (s_r.aw_addr)
      gx_pkg::OFS_CFG: wr_old = {24'h000000, s_r.cfg};
      gx_pkg::OFS_CTRL: wr_old = {30'h00000000, s_r.mode, s_r.en};
      gx_pkg::OFS_THR: wr_old = {10'h000, s_r.thr};
      default: wr_old = 32'h00000000;
    endcase
  end

  // next state: bus slave first, then hardware effects so a set wins
  always_comb begin
    logic [31:0] mv;
    mv = wmerge_w(wr_old, s_r.w_data, s_r.w_strb);
    s_nxt = s_r;
    clear_cnt = 1'b0;
    // park write address and data as they arrive, either order
    if (aw_go) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr;
    end
    if (w_go) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = axi_req.wdata;
      s_nxt.w_strb = axi_req.wstrb;
    end
    // apply the parked write and raise the response
    if (sw_wr) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = gx_pkg::RESP_OKAY;
      case (s_r.aw_addr)
        gx_pkg::OFS_CFG: s_nxt.cfg = mv[7:0];
        gx_pkg::OFS_CTRL: begin
          s_nxt.en = mv[gx_pkg::CTRL_EN_BIT];
          s_nxt.mode = mv[gx_pkg::CTRL_MODE_BIT];
        end
        gx_pkg::OFS_THR: s_nxt.thr = mv[gx_pkg::THR_W-1:0];
        default: s_nxt.bresp = gx_pkg::RESP_SLVERR; // status and holes
      endcase
    end else if (s_r.bvalid && axi_req.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // reads answer on the same edge that takes the address
    if (ar_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = gx_pkg::RESP_OKAY;
      case (axi_req.araddr)
        gx_pkg::OFS_CFG: s_nxt.rdata = {24'h000000, s_r.cfg};
        gx_pkg::OFS_CTRL: s_nxt.rdata = {30'h00000000, s_r.mode, s_r.en};
        gx_pkg::OFS_THR: s_nxt.rdata = {10'h000, s_r.thr};
        gx_pkg::OFS_STAT: s_nxt.rdata = {27'h0000000, end_count, s_r.st};
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = gx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && axi_req.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // engine state machine
    case (s_r.st)
      gx_pkg::ST_IDLE: begin
        // qualifying proximity result sets the state bit, over a clear
        if (s_nxt.en && prox_valid && entry_ok) begin
          s_nxt.mode = 1'b1;
        end
        if (s_nxt.en && s_nxt.mode) begin
          s_nxt.st = gx_pkg::ST_GEST;
          clear_cnt = 1'b1;
        end
      end
      gx_pkg::ST_GEST: begin
        if (!s_nxt.en || !s_nxt.mode) begin
          s_nxt.st = gx_pkg::ST_IDLE; // software leaves gesture
        end else if (cycle_done) begin
          if (exit_req) begin
            s_nxt.mode = 1'b0;
            s_nxt.st = gx_pkg::ST_IDLE;
          end else if (inter_cycle_wait != 3'h0) begin
            // idle in low power before the next cycle
            s_nxt.wait_cnt = gx_pkg::WAIT_CNT_W'(inter_cycle_wait * WAIT_CYC);
            s_nxt.st = gx_pkg::ST_WAIT;
          end
        end
      end
      gx_pkg::ST_WAIT: begin
        if (!s_nxt.en || !s_nxt.mode) begin
          s_nxt.st = gx_pkg::ST_IDLE;
        end else if (s_r.wait_cnt <= gx_pkg::WAIT_CNT_W'(1)) begin
          s_nxt.st = gx_pkg::ST_GEST;
        end else begin
          s_nxt.wait_cnt = s_r.wait_cnt - gx_pkg::WAIT_CNT_W'(1);
        end
      end
      default: s_nxt.st = gx_pkg::ST_IDLE;
    endcase
    // analog steering words, registered so they never glitch
    s_nxt.gain = 4'h1 << photodiode_gain_sel;
    // drive field only applies in gesture mode; full drive otherwise
    s_nxt.drive = (s_nxt.st != gx_pkg::ST_IDLE) ? led_drive_strength : 2'h0;
  end

  // thin wrapper so the merge reads as a local name
  function automatic logic [31:0] wmerge_w(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] b);
    wmerge_w = gx_pkg::wmerge(o, n, b);
  endfunction : wmerge_w

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.st <= gx_pkg::ST_IDLE;
      s_r.cfg <= gx_pkg::CFG_RST;
      s_r.thr <= gx_pkg::THR_RST;
      s_r.gain <= 4'h1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // the checks below watch registered state only; a software write that
  // commits in the same edge may override the engine, so such edges are
  // left out of the engine checks rather than modelled a second time
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // entry: always, on threshold, never without enable
  a_always_entry: assert property (
      s_r.st == gx_pkg::ST_IDLE && s_r.en && enter_always && prox_valid && !sw_wr
      |=> s_r.st == gx_pkg::ST_GEST && s_r.mode)
    else $error("enter-always did not enter gesture");
  a_thr_blocks: assert property (
      s_r.st == gx_pkg::ST_IDLE && !s_r.mode && !enter_always &&
      prox_valid && proximity_result < entry_threshold && !sw_wr
      |=> s_r.st == gx_pkg::ST_IDLE)
    else $error("entered below entry threshold");
  a_thr_enters: assert property (
      s_r.st == gx_pkg::ST_IDLE && s_r.en && !enter_always &&
      prox_valid && proximity_result >= entry_threshold && !sw_wr
      |=> s_r.st == gx_pkg::ST_GEST)
    else $error("result at entry threshold did not enter");
  a_no_entry_off: assert property (
      s_r.st == gx_pkg::ST_IDLE && !s_r.en && !sw_wr |=> s_r.st == gx_pkg::ST_IDLE)
    else $error("entered gesture with enable clear");

  // exit by persistence or by software
  a_exit_idle: assert property (
      s_r.st == gx_pkg::ST_GEST && s_r.en && s_r.mode && cycle_done && exit_req && !sw_wr
      |=> s_r.st == gx_pkg::ST_IDLE && !s_r.mode)
    else $error("exit request did not leave gesture");
  a_sw_leave: assert property (
      s_r.st != gx_pkg::ST_IDLE && sw_wr && s_r.aw_addr == gx_pkg::OFS_CTRL &&
      s_r.w_strb[0] && !s_r.w_data[gx_pkg::CTRL_MODE_BIT]
      |=> s_r.st == gx_pkg::ST_IDLE)
    else $error("state bit cleared but gesture kept");
  a_entry_clear: assert property (
      s_r.st == gx_pkg::ST_IDLE ##1 s_r.st == gx_pkg::ST_GEST |-> end_count == 3'h0)
    else $error("end counter not cleared on entry");

  // analog steering words
  a_gain_map: assert property (
      $stable(photodiode_gain_sel) |=> gain_mult == (4'h1 << $past(photodiode_gain_sel)))
    else $error("gain word does not match gain field");
  a_drive_map: assert property (
      s_r.st == gx_pkg::ST_GEST && $stable(led_drive_strength)
      |-> led_drive_shift == led_drive_strength)
    else $error("drive word does not match drive field");
  a_drive_idle: assert property (
      s_r.st == gx_pkg::ST_IDLE |-> led_drive_shift == 2'h0)
    else $error("drive word not full strength outside gesture");

  // low-power wait between cycles
  a_wait_entry: assert property (
      s_r.st == gx_pkg::ST_GEST && s_r.en && s_r.mode && cycle_done &&
      !exit_req && inter_cycle_wait != 3'h0 && !sw_wr |=> low_power)
    else $error("no low-power wait after a cycle");
  a_wait_holds: assert property (
      s_r.st == gx_pkg::ST_WAIT && s_r.en && s_r.mode && !sw_wr &&
      s_r.wait_cnt > gx_pkg::WAIT_CNT_W'(1) |=> low_power)
    else $error("low-power wait ended early");

  // register bus answers
  a_resp_hold: assert property (
      s_r.bvalid && !axi_req.bready |=> s_r.bvalid && $stable(s_r.bresp))
    else $error("write response dropped before bready");
  a_write_answer: assert property (sw_wr |=> s_r.bvalid)
    else $error("no write response after commit");
  a_read_answer: assert property (ar_go |=> s_r.rvalid)
    else $error("no read response after address taken");

endmodule : gx_gesture_ctrl

// ==== testbench/gx_gesture_ctrl_tb.sv ====
// self-checking bench for the gesture entry/exit controller
`timescale 1ns/100ps
module gx_gesture_ctrl_tb;
  localparam int unsigned WC = 4; // short wait step keeps the run brief
  localparam gx_pkg::gx_dirs_t END_D = 32'hff000000; // only masked north high
  localparam gx_pkg::gx_dirs_t MISS_D = 32'h00ff00ff; // south and east above threshold
  logic core_clk = 1'b0; // 25 MHz
  logic srst = 1'b1; // held for four edges
  gx_pkg::gx_axil_req_t req = '0; // bus master side
  gx_pkg::gx_axil_rsp_t rsp;
  logic prox_valid = 1'b0;
  logic [7:0] proximity_result = 8'h00;
  logic cycle_done = 1'b0;
  gx_pkg::gx_dirs_t dirs = '0;
  logic gesture_active;
  logic cycle_req;
  logic low_power;
  logic [3:0] gain_mult;
  logic [1:0] led_drive_shift;
  int err_count = 0; // mismatches
  int num_checks = 0; // comparisons made
  int cyc_n = 0; // cycles since start
  logic [31:0] rv; // last read data
  logic [1:0] rr; // last response code

  gx_gesture_ctrl #(.WAIT_CYC(WC)) gx_gesture_ctrl_i (
    .core_clk(core_clk),
    .srst(srst),
    .axi_req(req),
    .axi_rsp(rsp),
    .prox_valid(prox_valid),
    .proximity_result(proximity_result),
    .cycle_done(cycle_done),
    .dirs(dirs),
    .gesture_active(gesture_active),
    .cycle_req(cycle_req),
    .low_power(low_power),
    .gain_mult(gain_mult),
    .led_drive_shift(led_drive_shift)
  );

  // free-running clock
  always #20 core_clk = ~core_clk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // counts and verdict, the only exit
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // value compare, four-state exact
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one write; readiness looked at before the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    input logic [3:0] s = 4'hf);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    while (aw || w) begin
      @(negedge core_clk);
      if (rsp.awready === 1'b1) aw = 1'b0;
      if (rsp.wready === 1'b1) w = 1'b0;
      @(posedge core_clk);
      req.awvalid <= aw;
      req.wvalid <= w;
    end
    do begin
      @(negedge core_clk);
      r = rsp.bresp;
    end while (rsp.bvalid !== 1'b1);
    @(posedge core_clk);
    req.bready <= 1'b0;
    @(posedge core_clk); // spacing so bready is not set twice in one step
  endtask : wr

  // one read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (ar) begin
      @(negedge core_clk);
      if (rsp.arready === 1'b1) ar = 1'b0;
      @(posedge core_clk);
      req.arvalid <= ar;
    end
    do begin
      @(negedge core_clk);
      d = rsp.rdata;
      r = rsp.rresp;
    end while (rsp.rvalid !== 1'b1);
    @(posedge core_clk);
    req.rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  // one proximity result pulse, then settle
  task automatic prox(input logic [7:0] v);
    prox_valid <= 1'b1;
    proximity_result <= v;
    @(posedge core_clk);
    prox_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : prox

  // one finished detection cycle
  task automatic cyc(input gx_pkg::gx_dirs_t d);
    cycle_done <= 1'b1;
    dirs <= d;
    @(posedge core_clk);
    cycle_done <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : cyc

  // reset values, read-back width, refused places
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4), rv, rr);
      chk("reg_reset", 32'h0, rv);
      chk("reg_resp", 32'(gx_pkg::RESP_OKAY), 32'(rr));
    end
    chk("gain_reset", 32'h1, 32'(gain_mult));
    chk("drive_reset", 32'h0, 32'(led_drive_shift));
    rd(8'h10, rv, rr);
    chk("unmapped_rresp", 32'(gx_pkg::RESP_SLVERR), 32'(rr));
    chk("unmapped_rdata", 32'h0, rv);
    wr(8'h10, 32'hffffffff, rr);
    chk("unmapped_bresp", 32'(gx_pkg::RESP_SLVERR), 32'(rr));
    wr(gx_pkg::OFS_STAT, 32'hffffffff, rr);
    chk("status_bresp", 32'(gx_pkg::RESP_SLVERR), 32'(rr));
    rd(gx_pkg::OFS_STAT, rv, rr);
    chk("status_kept", 32'h0, rv);
    wr(gx_pkg::OFS_THR, 32'hffffffff, rr);
    rd(gx_pkg::OFS_THR, rv, rr);
    chk("thr_width", 32'h003fffff, rv);
    wr(gx_pkg::OFS_THR, 32'h00000000, rr, 4'h2); // only byte lane one written
    rd(gx_pkg::OFS_THR, rv, rr);
    chk("thr_strobe", 32'h003f00ff, rv);
  endtask : t_reset

  // every gain and drive code, drive applied only in gesture
  task automatic t_gain_drive();
    for (int g = 0; g < 4; g++) begin
      wr(gx_pkg::OFS_CFG, {24'h0, 1'b1, 2'(g), 2'(g), 3'h0}, rr);
      chk("gain_mult", 32'(4'h1 << g), 32'(gain_mult));
      wr(gx_pkg::OFS_CTRL, 32'h1, rr);
      chk("drive_idle", 32'h0, 32'(led_drive_shift));
      prox(8'h00);
      chk("drive_shift", 32'(g), 32'(led_drive_shift));
    end
    wr(gx_pkg::OFS_CTRL, 32'h1, rr);
  endtask : t_gain_drive

  // conditional entry at the threshold boundary
  task automatic t_entry_cond();
    wr(gx_pkg::OFS_CFG, 32'h0, rr);
    wr(gx_pkg::OFS_THR, {10'h0, 2'h0, 4'h0, 8'h10, 8'h40}, rr);
    prox(8'h3f);
    chk("below_entry", 32'h0, 32'(gesture_active));
    prox(8'h40);
    chk("at_entry", 32'h1, 32'(gesture_active));
    wr(gx_pkg::OFS_CTRL, 32'h1, rr);
  endtask : t_entry_cond

  // each persistence code, a miss in mid-count restarts it
  task automatic t_persist();
    int n;
    wr(gx_pkg::OFS_CFG, 32'h80, rr);
    for (int p = 0; p < 4; p++) begin
      n = (p == 3) ? 7 : (1 << p);
      wr(gx_pkg::OFS_THR, {10'h0, 2'(p), 4'h8, 8'h10, 8'h00}, rr);
      prox(8'h00);
      chk("enter_zero", 32'h1, 32'(gesture_active));
      repeat (n - 1) cyc(END_D);
      cyc(MISS_D);
      repeat (n - 1) cyc(END_D);
      chk("held_after_miss", 32'h1, 32'(gesture_active));
      rd(gx_pkg::OFS_STAT, rv, rr);
      chk("status_count", {27'h0, 3'(n - 1), 2'h1}, rv);
      cyc(END_D);
      chk("exit_at_count", 32'h0, 32'(gesture_active));
    end
  endtask : t_persist

  // zero exit threshold leaves only on software clear
  task automatic t_zero_exit();
    // all detectors masked: only the zero-threshold guard keeps it in gesture
    wr(gx_pkg::OFS_THR, {10'h0, 2'h0, 4'hf, 8'h00, 8'h00}, rr);
    prox(8'h00);
    repeat (3) cyc(32'h0);
    chk("zero_thr_stays", 32'h1, 32'(gesture_active));
    wr(gx_pkg::OFS_CTRL, 32'h1, rr);
    chk("sw_clear_exits", 32'h0, 32'(gesture_active));
  endtask : t_zero_exit

  // low-power time between cycles for wait code 2
  task automatic t_wait();
    int n;
    wr(gx_pkg::OFS_CFG, 32'h82, rr);
    wr(gx_pkg::OFS_THR, {10'h0, 2'h3, 4'h0, 8'h10, 8'h00}, rr);
    prox(8'h00);
    cycle_done <= 1'b1;
    dirs <= MISS_D;
    @(posedge core_clk);
    cycle_done <= 1'b0;
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      if (low_power === 1'b1) n++;
    end
    @(posedge core_clk);
    chk("wait_cycles", 32'(2 * WC), 32'(n));
    chk("back_to_cycle", 32'h1, 32'(cycle_req));
    wr(gx_pkg::OFS_CTRL, 32'h0, rr);
  endtask : t_wait

  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_gain_drive();
    t_entry_cond();
    t_persist();
    t_zero_exit();
    t_wait();
    give_verdict();
  end
endmodule : gx_gesture_ctrl_tb
